// ===== rtl/stap_pkg.sv
// Constants for the scan test access port: instructions, identity layout, timing.
// Assumes a single core clock; the scan clock is sampled as ordinary data.
package stap_pkg;

    // =====================================================================
    // Widths
    localparam int IR_W = 4;
    localparam int DR_W = 32;

    // =====================================================================
    // Instruction codes
    localparam logic [IR_W-1:0] INS_EXTEST   = 4'h0;
    localparam logic [IR_W-1:0] INS_DEVICE_IDENTITY_WORD   = 4'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE   = 4'h2;
    localparam logic [IR_W-1:0] INS_USERCODE = 4'h3;
    localparam logic [IR_W-1:0] INS_CHIPTAP  = 4'h4;
    localparam logic [IR_W-1:0] INS_PLLWRITE = 4'h8;
    localparam logic [IR_W-1:0] INS_BYPASS   = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE   = 4'h1;

    // =====================================================================
    // Identity word fields (values arbitrary, not those of any real part).
    localparam logic [3:0]  ID_VERSION  = 4'h0;
    localparam logic [15:0] ID_PART     = 16'h0abc;
    localparam logic [10:0] ID_MAKER    = 11'h155;
    localparam logic        ID_MARKER   = 1'b1;

    // =====================================================================
    // User code layout.
    localparam int          UID_W       = 14;
    localparam int          UID_LSB     = 18;
    localparam int          REV_W       = 18;
    localparam logic [17:0] SILICON_REV = 18'h02800;

    // =====================================================================
    // Security bits and the TMS run count for reset.
    localparam int SEC_W          = 10;
    localparam int SEC_SCAN_OFF   = 0;
    localparam int SEC_PLL_LOCK   = 4;
    localparam int TMS_RESET_RUNS = 5;

    typedef enum logic [3:0] {
        STAP_RESET, STAP_IDLE, STAP_SEL_DR, STAP_CAP_DR, STAP_SH_DR, STAP_EX1_DR,
        STAP_PAU_DR, STAP_EX2_DR, STAP_UPD_DR, STAP_SEL_IR, STAP_CAP_IR, STAP_SH_IR,
        STAP_EX1_IR, STAP_PAU_IR, STAP_EX2_IR, STAP_UPD_IR
    } stap_state_e;

endpackage : stap_pkg

// ===== rtl/stap_ctrl.sv
// Test access port controller state machine, advanced by one-cycle scan edge enables.
// Assumes TMS arrives already synchronised to core_clk.
module stap_ctrl
    import stap_pkg::*;
(
    // Clock and reset
    input  wire logic  core_clk,
    input  wire logic  reset,
    // Scan controls
    input  wire logic  tck_rise,
    input  wire logic  tms,
    // State
    output stap_state_e state_q
);

    stap_state_e state_d;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            STAP_RESET:  state_d = tms ? STAP_RESET  : STAP_IDLE;
            STAP_IDLE:   state_d = tms ? STAP_SEL_DR : STAP_IDLE;
            STAP_SEL_DR: state_d = tms ? STAP_SEL_IR : STAP_CAP_DR;
            STAP_CAP_DR: state_d = tms ? STAP_EX1_DR : STAP_SH_DR;
            STAP_SH_DR:  state_d = tms ? STAP_EX1_DR : STAP_SH_DR;
            STAP_EX1_DR: state_d = tms ? STAP_UPD_DR : STAP_PAU_DR;
            STAP_PAU_DR: state_d = tms ? STAP_EX2_DR : STAP_PAU_DR;
            STAP_EX2_DR: state_d = tms ? STAP_UPD_DR : STAP_SH_DR;
            STAP_UPD_DR: state_d = tms ? STAP_SEL_DR : STAP_IDLE;
            STAP_SEL_IR: state_d = tms ? STAP_RESET  : STAP_CAP_IR;
            STAP_CAP_IR: state_d = tms ? STAP_EX1_IR : STAP_SH_IR;
            STAP_SH_IR:  state_d = tms ? STAP_EX1_IR : STAP_SH_IR;
            STAP_EX1_IR: state_d = tms ? STAP_UPD_IR : STAP_PAU_IR;
            STAP_PAU_IR: state_d = tms ? STAP_EX2_IR : STAP_PAU_IR;
            STAP_EX2_IR: state_d = tms ? STAP_UPD_IR : STAP_SH_IR;
            STAP_UPD_IR: state_d = tms ? STAP_SEL_DR : STAP_IDLE;
        endcase
    end

    // The graph reaches reset from any state within five high TMS edges.
    always_ff @(posedge core_clk)
    begin
        if (reset)
            state_q <= STAP_RESET;
        else if (tck_rise)
            state_q <= state_d;
    end

endmodule : stap_ctrl

// ===== rtl/stap_top.sv
// Boundary-scan access port with identity, user code, chip-port route and PLL write.
// Assumes TCK, TMS, TDI, security and reset-state inputs are asynchronous to core_clk;
// the scan clock must be well below half the core clock rate.

// ========================================================================
// Overview of operation
// - One standard test access port, with boundary scan of the I/O pins.
// - Instruction register is four bits; data register is thirty-two bits.
// - A chip-port instruction routes scan data to the inner tile port.
// - Five test clocks with mode select high return the logic to reset.
// - Identity instruction shifts out the fixed thirty-two bit identity word.
// - User code instruction shifts out the thirty-two bit user code word.
// - User identifier comes from low fourteen bits of the programmed word.
// - User identifier loads only after device reset releases; zero before.
// - Instruction eight writes the shifted data word into PLL settings.
// - PLL settings hold a device reset bit and a scan boot bit.
// - User identifier sits at bits 31 down to 18 of the user code.
// - Security bit 0 blocks the chip-port route to the inner tile port.
// - Security bit 4 refuses scan writes to the PLL settings register.
module stap_top
    import stap_pkg::*;
(
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            reset,
    // Scan pins
    input  wire logic            tck,
    input  wire logic            tms,
    input  wire logic            tdi,
    output logic                 tdo,
    output logic                 tdo_oe,
    // Device side
    input  wire logic            device_in_reset,
    input  wire logic [13:0]     programmed_user_identifier,
    input  wire logic [SEC_W-1:0] security_config,
    // Boundary cells
    input  wire logic [DR_W-1:0] pin_sample,
    output logic      [DR_W-1:0] pin_drive,
    output logic                 pin_extest,
    // Inner chip port
    output logic                 chip_tck,
    output logic                 chip_tms,
    output logic                 chip_tdi,
    input  wire logic            chip_tdo,
    // PLL settings
    output logic      [DR_W-1:0] pll_settings,
    output logic                 pll_write,
    output logic                 device_reset_req,
    output logic                 boot_from_scan
);

    // ====================================================================
    // Input synchronisers
    logic [1:0] tck_s_q, tms_s_q, tdi_s_q, ctdo_s_q, drst_s_q;
    logic [1:0] sec0_s_q, sec4_s_q;
    logic [13:0] uid_s1_q, uid_s2_q;
    logic       tck_d1_q;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            tck_s_q  <= 2'h0;
            tms_s_q  <= 2'h3;
            tdi_s_q  <= 2'h0;
            ctdo_s_q <= 2'h0;
            drst_s_q <= 2'h3;
            sec0_s_q <= 2'h3;
            sec4_s_q <= 2'h3;
            uid_s1_q <= 14'h0000;
            uid_s2_q <= 14'h0000;
            tck_d1_q <= 1'b0;
        end
        else
        begin
            tck_s_q  <= {tck_s_q[0], tck};
            tms_s_q  <= {tms_s_q[0], tms};
            tdi_s_q  <= {tdi_s_q[0], tdi};
            ctdo_s_q <= {ctdo_s_q[0], chip_tdo};
            drst_s_q <= {drst_s_q[0], device_in_reset};
            sec0_s_q <= {sec0_s_q[0], security_config[SEC_SCAN_OFF]};
            sec4_s_q <= {sec4_s_q[0], security_config[SEC_PLL_LOCK]};
            uid_s1_q <= programmed_user_identifier;
            uid_s2_q <= uid_s1_q;
            tck_d1_q <= tck_s_q[1];
        end
    end

    // Scan edges are found by the core clock, so TCK must be slow against it.
    logic tck_rise, tck_fall;
    assign tck_rise = tck_s_q[1] & ~tck_d1_q;
    assign tck_fall = ~tck_s_q[1] & tck_d1_q;

    // ====================================================================
    // Boundary samples
    // Each pin is synchronised on its own, so a capture may mix pins that change together.
    logic [DR_W-1:0] pins_s1_q, pins_s2_q;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pins_s1_q <= '0;
            pins_s2_q <= '0;
        end
        else
        begin
            pins_s1_q <= pin_sample;
            pins_s2_q <= pins_s1_q;
        end
    end

    // ====================================================================
    // Controller
    stap_state_e state_q;

    stap_ctrl u_ctrl (
        .core_clk (core_clk),
        .reset    (reset),
        .tck_rise (tck_rise),
        .tms      (tms_s_q[1]),
        .state_q  (state_q)
    );

    // ====================================================================
    // Instruction register
    logic [IR_W-1:0] ir_sh_q, ir_q;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ir_sh_q <= INS_DEVICE_IDENTITY_WORD;
            ir_q    <= INS_DEVICE_IDENTITY_WORD;
        end
        else if (tck_rise)
        begin
            unique case (state_q)
                STAP_RESET:  ir_q    <= INS_DEVICE_IDENTITY_WORD;
                STAP_CAP_IR: ir_sh_q <= IR_CAPTURE;
                STAP_SH_IR:  ir_sh_q <= {tdi_s_q[1], ir_sh_q[IR_W-1:1]};
                STAP_UPD_IR: ir_q    <= ir_sh_q;
                default:     ir_q    <= ir_q;
            endcase
        end
    end

    // ====================================================================
    // Fixed words
    logic [DR_W-1:0] id_word, user_word;
    logic [13:0]     uid_q, uid_s3_q;

    assign id_word = {ID_VERSION, ID_PART, ID_MAKER, ID_MARKER};

    // The identifier is cleared during device reset, as boot firmware reloads it.
    // The word crosses as a whole, so it is taken only once two samples in a row agree.
    always_ff @(posedge core_clk)
    begin
        if (reset || drst_s_q[1])
        begin
            uid_s3_q <= 14'h0000;
            uid_q    <= 14'h0000;
        end
        else
        begin
            uid_s3_q <= uid_s2_q;
            if (uid_s2_q == uid_s3_q)
                uid_q <= uid_s2_q;
        end
    end

    assign user_word = {uid_q, SILICON_REV};

    // ====================================================================
    // Data register
    logic [DR_W-1:0] dr_q;
    logic            byp_q;
    logic            scan_off, chip_sel;

    assign scan_off = sec0_s_q[1];
    assign chip_sel = (ir_q == INS_CHIPTAP) && !scan_off;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            dr_q  <= '0;
            byp_q <= 1'b0;
        end
        else if (tck_rise)
        begin
            if (state_q == STAP_CAP_DR)
            begin
                byp_q <= 1'b0;
                unique case (ir_q)
                    INS_DEVICE_IDENTITY_WORD:   dr_q <= id_word;
                    INS_USERCODE: dr_q <= user_word;
                    INS_EXTEST,
                    INS_SAMPLE:   dr_q <= pins_s2_q;
                    default:      dr_q <= '0;
                endcase
            end
            else if (state_q == STAP_SH_DR)
            begin
                dr_q  <= {tdi_s_q[1], dr_q[DR_W-1:1]};
                byp_q <= tdi_s_q[1];
            end
        end
    end

    // ====================================================================
    // Boundary update and PLL write
    // A locked write leaves the settings untouched and raises no pulse.
    logic pll_lock;
    assign pll_lock = sec4_s_q[1];

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pin_drive    <= '0;
            pin_extest   <= 1'b0;
            pll_settings <= '0;
            pll_write    <= 1'b0;
        end
        else
        begin
            pll_write  <= 1'b0;
            pin_extest <= (ir_q == INS_EXTEST) && (state_q != STAP_RESET);
            if (tck_rise && state_q == STAP_UPD_DR)
            begin
                if (ir_q == INS_EXTEST || ir_q == INS_SAMPLE)
                    pin_drive <= dr_q;
                if (ir_q == INS_PLLWRITE && !pll_lock)
                begin
                    pll_settings <= dr_q;
                    pll_write    <= 1'b1;
                end
            end
        end
    end

    // Reset and boot controls sit in the top bits of the settings word.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            device_reset_req <= 1'b0;
            boot_from_scan   <= 1'b0;
        end
        else
        begin
            device_reset_req <= pll_settings[DR_W-1];
            boot_from_scan   <= pll_settings[DR_W-2];
        end
    end

    // ====================================================================
    // Inner port route and TDO
    // Outside the route the inner port sees mode select high with its clock held low, so it gets no edges.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            chip_tck <= 1'b0;
            chip_tms <= 1'b1;
            chip_tdi <= 1'b0;
        end
        else
        begin
            chip_tck <= chip_sel & tck_s_q[1];
            chip_tms <= chip_sel ? tms_s_q[1] : 1'b1;
            chip_tdi <= chip_sel & tdi_s_q[1];
        end
    end

    // TDO changes on the falling scan edge, as the standard requires.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_oe <= (state_q == STAP_SH_DR) || (state_q == STAP_SH_IR);
            if (state_q == STAP_SH_IR)
                tdo <= ir_sh_q[0];
            else if (chip_sel)
                tdo <= ctdo_s_q[1];
            else if (ir_q == INS_BYPASS || ir_q == INS_CHIPTAP || ir_q == INS_PLLWRITE)
                tdo <= (ir_q == INS_PLLWRITE) ? dr_q[0] : byp_q;
            else
                tdo <= dr_q[0];
        end
    end

endmodule : stap_top

// ===== tb/stap_top_sva.sv
// Checker for the scan access port: scan output timing, chip route and PLL path.
// Assumes it is bound to stap_top and sees only that module's ports.
module stap_top_sva
    import stap_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // Scan pins
    input  wire logic             tck,
    input  wire logic             tdo,
    input  wire logic             tdo_oe,
    input  wire logic [SEC_W-1:0] security_config,
    // Outputs watched
    input  wire logic [DR_W-1:0]  pin_drive,
    input  wire logic             chip_tck,
    input  wire logic             chip_tms,
    input  wire logic             chip_tdi,
    input  wire logic [DR_W-1:0]  pll_settings,
    input  wire logic             pll_write,
    input  wire logic             device_reset_req,
    input  wire logic             boot_from_scan
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // =====================================================================
    // Security bits pass two flops, so five cycles held means they are settled.
    sequence s_lock_held;
        security_config[SEC_PLL_LOCK] [*5];
    endsequence
    sequence s_scan_off;
        security_config[SEC_SCAN_OFF] [*5];
    endsequence

    a_lock_no_write: assert property (s_lock_held |=> !pll_write)
        else $error("PLL write while locked");
    a_scan_off_idle: assert property (s_scan_off |=> !chip_tck && chip_tms && !chip_tdi)
        else $error("chip route active while scan access is off");
    a_write_one_cycle: assert property (pll_write |=> !pll_write)
        else $error("PLL write pulse longer than one cycle");
    a_pll_hold: assert property (!$stable(pll_settings) |-> pll_write || $past(pll_write))
        else $error("PLL settings changed without a write");
    a_ctrl_bits: assert property ({device_reset_req, boot_from_scan} == $past(pll_settings[31:30]))
        else $error("reset or boot bit does not follow PLL settings");
    a_write_on_rise: assert property (pll_write |-> $past(tck))
        else $error("PLL write not after a rising scan clock");
    a_tdo_on_fall: assert property (!$stable(tdo) |-> !tck && !$past(tck))
        else $error("tdo changed outside the low scan clock phase");
    a_oe_on_fall: assert property ($rose(tdo_oe) |-> !tck)
        else $error("tdo enable rose while scan clock high");
    a_pin_update: assert property (!$stable(pin_drive) |-> $past(tck))
        else $error("pin drive updated off a rising scan clock");
endmodule : stap_top_sva

bind stap_top stap_top_sva stap_top_sva_i (.core_clk, .reset, .tck, .tdo, .tdo_oe,
    .security_config, .pin_drive, .chip_tck, .chip_tms, .chip_tdi, .pll_settings,
    .pll_write, .device_reset_req, .boot_from_scan);

// ===== tb/stap_host.sv
// Scan host model: drives the scan pins from core_clk and shifts whole frames.
// Assumes tdo settles three core cycles after a falling scan clock.
module stap_host
    import stap_pkg::*;
(
    // Clock
    input  wire logic core_clk,
    // Scan pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // =====================================================================
    // One scan clock of eight core cycles; tdo is taken just before the rise.
    task automatic cyc(input logic m, input logic v, output logic o);
        @(posedge core_clk);
        tck <= 1'b0;
        tms <= m;
        tdi <= v;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        o = tdo;
        @(posedge core_clk);
        tck <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask : cyc

    task automatic go_reset();
        logic o;
        repeat (5) cyc(1'b1, 1'b0, o);
        cyc(1'b0, 1'b0, o);
    endtask : go_reset

    // The clock stands high between calls, so a slow host is modelled too.
    task automatic idle(input int n);
        logic o;
        repeat (n) cyc(1'b0, 1'b0, o);
    endtask : idle

    task automatic scan(input logic ir, input logic [DR_W-1:0] v, input int n,
                        output logic [DR_W-1:0] q);
        logic o;
        q = '0;
        cyc(1'b1, 1'b0, o);
        if (ir)
            cyc(1'b1, 1'b0, o);
        cyc(1'b0, 1'b0, o);
        cyc(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++)
        begin
            cyc(i == n - 1, v[i], o);
            q[i] = o;
        end
        cyc(1'b1, 1'b0, o);
        cyc(1'b0, 1'b0, o);
        // One more edge, so what the update edge launched has settled for the caller.
        @(posedge core_clk);
    endtask : scan
endmodule : stap_host

// ===== tb/stap_top_test.sv
// Bench for the scan access port: reference words, PLL path, chip route, verdict.
// Assumes stap_host drives the scan pins and stap_top_sva is bound to the design.
module stap_top_test
    import stap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, reset, tck, tms, tdi, tdo, tdo_oe, device_in_reset, chip_tdo;
    logic pin_extest, chip_tck, chip_tms, chip_tdi, pll_write, device_reset_req, boot_from_scan;
    logic [13:0]      programmed_user_identifier;
    logic [SEC_W-1:0] security_config;
    logic [DR_W-1:0]  pin_sample, pin_drive, pll_settings, q, d;
    logic [IR_W-1:0]  codes [5];
    int               seed = 32'h2ba6;
    int               failures = 0;
    int               n_checks = 0;
    int               chip_rises = 0;
    int               writes = 0;

    stap_top stap_top_i (.core_clk, .reset, .tck, .tms, .tdi, .tdo, .tdo_oe, .device_in_reset,
        .programmed_user_identifier, .security_config, .pin_sample, .pin_drive, .pin_extest,
        .chip_tck, .chip_tms, .chip_tdi, .chip_tdo, .pll_settings, .pll_write,
        .device_reset_req, .boot_from_scan);
    stap_host stap_host_i (.core_clk, .tck, .tms, .tdi, .tdo);

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        // The inner port is modelled as a one-bit path that echoes its data in.
        chip_tdo <= chip_tdi;
        if (pll_write === 1'b1)
            writes++;
    end
    always @(posedge chip_tck)
        chip_rises++;

    // =====================================================================
    // Reference model and comparison.
    function automatic logic [DR_W-1:0] model(input logic [IR_W-1:0] ir,
                                              input logic [DR_W-1:0] v);
        case (ir)
            INS_DEVICE_IDENTITY_WORD:   return {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
            INS_USERCODE: return {device_in_reset ? 14'h0 : programmed_user_identifier,
                                  SILICON_REV};
            INS_BYPASS:   return {v[30:0], 1'b0};
            default:      return pin_sample;
        endcase
    endfunction : model

    task automatic check(input string what, input logic [DR_W-1:0] seen,
                         input logic [DR_W-1:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic load_ir(input logic [IR_W-1:0] ir);
        stap_host_i.scan(1'b1, 32'(ir), IR_W, q);
        check("ir capture", q, 32'(IR_CAPTURE));
    endtask : load_ir

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run

    // The tests need about 6000 core cycles; the limit allows several times that.
    initial
    begin
        #4000000;
        failures++;
        complete_run();
    end

    initial
    begin
        reset = 1'b1;
        device_in_reset = 1'b1;
        programmed_user_identifier = '0;
        security_config = '0;
        chip_tdo = 1'b0;
        pin_sample = $random(seed);
        codes = '{INS_EXTEST, INS_SAMPLE, INS_USERCODE, INS_BYPASS, INS_DEVICE_IDENTITY_WORD};
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("chip_tms", 32'(chip_tms), 32'h1);
        stap_host_i.go_reset();
        for (int k = -1; k < 5; k++)
        begin
            if (k >= 0)
                load_ir(codes[k]);
            d = $random(seed);
            stap_host_i.scan(1'b0, d, DR_W, q);
            check("dr word", q, model(k < 0 ? INS_DEVICE_IDENTITY_WORD : codes[k], d));
            if (k == 0)
            begin
                check("extest drive", pin_drive, d);
                check("extest mode", 32'(pin_extest), 32'h1);
            end
        end
        $display("instruction sweep done");
        device_in_reset <= 1'b0;
        programmed_user_identifier <= 14'($random(seed));
        load_ir(INS_USERCODE);
        stap_host_i.scan(1'b0, d, DR_W, q);
        check("user code", q, model(INS_USERCODE, d));
        $display("user code done");
        load_ir(INS_PLLWRITE);
        d = $random(seed);
        stap_host_i.scan(1'b0, d, DR_W, q);
        stap_host_i.idle(100);
        check("pll word", pll_settings, d);
        check("pll bits", 32'({device_reset_req, boot_from_scan}), 32'(d[31:30]));
        security_config <= 10'h010;
        stap_host_i.scan(1'b0, ~d, DR_W, q);
        stap_host_i.idle(100);
        check("pll locked", pll_settings, d);
        check("pll writes", 32'(writes), 32'h1);
        $display("pll path done");
        security_config <= 10'h001;
        load_ir(INS_CHIPTAP);
        chip_rises = 0;
        stap_host_i.scan(1'b0, d, 8, q);
        check("chip blocked", 32'(chip_rises), 32'h0);
        check("chip blocked tdo", q, model(INS_BYPASS, d) & 32'h000000ff);
        security_config <= '0;
        stap_host_i.scan(1'b0, d, 8, q);
        check("chip route", 32'(chip_rises > 0), 32'h1);
        check("chip route tdo", q, model(INS_BYPASS, d) & 32'h000000ff);
        $display("chip route done");
        stap_host_i.go_reset();
        stap_host_i.scan(1'b0, d, DR_W, q);
        check("id after reset", q, model(INS_DEVICE_IDENTITY_WORD, d));
        $display("scan reset done");
        complete_run();
    end
endmodule : stap_top_test
